// *** portrait_clock_stride_control_bench.sv ***
// Self-checking bench for the portrait clock and stride block.
`timescale 1ns/1ps
`default_nettype none
module portrait_clock_stride_control_bench
  import psc_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hang, hreadyout, hresp, pix_vld, pix_rgb_vld;
  logic pclk_en, mclk_en, portrait, alternate, line_start, frame_start;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pix_idx;
  logic [RGB_W-1:0] pix_rgb;
  logic [8:0] stride_bytes;
  int n_fail = 0;
  int n_compared = 0;
  always #5 hclk = ~hclk;
  psc_host host_u (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hang);
  psc_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pix_idx,
    .pix_vld, .pix_rgb, .pix_rgb_vld, .pclk_en, .mclk_en, .portrait,
    .alternate, .stride_bytes, .line_start, .frame_start);
  // ---------------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  always @(posedge hang) begin
    n_fail++;
    close_out();
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] junk;
    host_u.xfer(1'b1, idx, d, junk);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] idx,
                       input logic [31:0] exp);
    logic [31:0] v;
    host_u.xfer(1'b0, idx, 32'h0, v);
    chk(nm, v, exp);
  endtask : rdchk
  function automatic logic hit(input int s);
    return s == 0 ? pclk_en === 1'b1 :
           s == 1 ? mclk_en === 1'b1 : line_start === 1'b1;
  endfunction : hit
  // Counts cycles between two pulses; the first pulse is only awaited.
  task automatic gap(input int s, output int n);
    int k;
    k = 0;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      k++;
    end while (!hit(s) && k < 200);
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (!hit(s) && n < 200);
    if (n >= 200) begin
      n_fail++;
      close_out();
    end
  endtask : gap
  task automatic pixel(input logic [RGB_W-1:0] e);
    @(posedge hclk);
    pix_idx <= 8'h05;
    pix_vld <= 1'b1;
    @(posedge hclk);
    pix_vld <= 1'b0;
    @(posedge hclk);
    #1;
    chk("rgb_vld", {31'h0, pix_rgb_vld}, 32'h1);
    chk("rgb", {20'h0, pix_rgb}, {20'h0, e});
  endtask : pixel
  // ---------------------------------------------------------------------
  // Sequence of tests.
  // ---------------------------------------------------------------------
  initial begin
    int p, m, b, pe, me;
    static int pa[4] = '{2, 2, 4, 8};
    static int ma[4] = '{1, 1, 2, 4};
    static logic [31:0] sv[4] = '{32'h00, 32'h01, 32'h80, 32'hFF};
    static logic [11:0] rgb[4] = '{12'hA5C, 12'h5A3, 12'h555, 12'hAAA};
    pix_idx = 8'h00;
    pix_vld = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("mode_rst", IDX_MODE, 32'h0);
    chk("stride_rst", {23'h0, stride_bytes}, 32'h100);
    rdchk("test_a", IDX_TEST_A, 32'h0);
    rdchk("test_b", IDX_TEST_B, 32'h0);
    rdchk("unmapped", 8'h3F, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(IDX_STRIDE, sv[i]);
      rdchk("stride", IDX_STRIDE, sv[i]);
      chk("stride_bytes", {23'h0, stride_bytes},
          (sv[i] == 32'h0) ? 32'h100 : sv[i]);
    end
    $display("test stride done");
    for (int c = 0; c < 2; c++) begin
      wr(IDX_CLKCFG, (c == 1) ? 32'h30 : 32'h0);
      b = c + 1;
      for (int en = 0; en < 2; en++) begin
        for (int al = 0; al < 2; al++) begin
          for (int sl = 0; sl < 4; sl++) begin
            wr(IDX_MODE, {24'h0, 1'(en), 1'(al), 4'h4, 2'(sl)});
            gap(0, p);
            gap(1, m);
            gap(0, p);
            gap(1, m);
            pe = (en == 0) ? b : (al == 1) ? b * pa[sl] : b << sl;
            me = (en == 0) ? b * b : (al == 1) ? b * ma[sl] : b << sl;
            chk("pclk", p, pe);
            chk("mclk", m, me);
            chk("portrait", {31'h0, portrait}, en);
            chk("alternate", {31'h0, alternate}, en & al);
          end
        end
      end
    end
    $display("test clocks done");
    wr(IDX_MODE, 32'h0);
    wr(IDX_CLKCFG, 32'h0);
    wr(IDX_HSIZE, 32'h82);
    wr(IDX_HBLANK, 32'hE1);
    wr(IDX_VSIZE_LO, 32'h02);
    wr(IDX_VSIZE_HI, 32'hFD);
    wr(IDX_VBLANK, 32'hC5);
    rdchk("hsize", IDX_HSIZE, 32'h02);
    rdchk("hblank", IDX_HBLANK, 32'h01);
    rdchk("vsize_hi", IDX_VSIZE_HI, 32'h01);
    rdchk("vblank", IDX_VBLANK, 32'h05);
    rdchk("line", IDX_LINE_LEN,
          (2 + 1) * 8 + (1 + 4) * 8);
    rdchk("frame", IDX_FRAME_LEN,
          64 * (259 + 5));
    gap(2, p);
    gap(2, p);
    chk("line_gap", p, 64);
    wr(IDX_PANEL, 32'h01);
    rdchk("line_dual", IDX_LINE_LEN, 128);
    rdchk("frame_dual", IDX_FRAME_LEN, 128 * (259 / 2 + 5));
    $display("test timing done");
    wr(IDX_LUT_ADDR, 32'h05);
    wr(IDX_LUT_DATA, 32'hA5C);
    wr(IDX_LUT_ADDR, 32'h05);
    rdchk("lut", IDX_LUT_DATA, 32'hA5C);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PANEL, 32'(2 * i));
      pixel(rgb[i]);
    end
    $display("test pixel done");
    close_out();
  end
endmodule : portrait_clock_stride_control_bench
bind psc_top psc_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pix_vld,
  .pix_rgb_vld, .pclk_en, .mclk_en, .portrait, .alternate, .stride_bytes,
  .line_start, .frame_start);
`default_nettype wire

// *** psc_chk.sv ***
// Port checker for the portrait clock and stride block.
`timescale 1ns/1ps
`default_nettype none
module psc_chk
  import psc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pix_vld,
  input wire logic pix_rgb_vld,
  input wire logic pclk_en,
  input wire logic mclk_en,
  input wire logic portrait,
  input wire logic alternate,
  input wire logic [8:0] stride_bytes,
  input wire logic line_start,
  input wire logic frame_start
);
  // ---------------------------------------------------------------------
  // Data phase tracking.
  // ---------------------------------------------------------------------
  logic rd_ph_ff;
  logic wr_ph_ff;
  logic [7:0] idx_ff;
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_ff <= 1'b0;
      wr_ph_ff <= 1'b0;
      idx_ff <= 8'h00;
    end else begin
      rd_ph_ff <= take && !hwrite;
      wr_ph_ff <= take && hwrite;
      idx_ff <= haddr[IDX_MSB:IDX_LSB];
    end
  end
  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [7:0] i);
    rd_ph_ff && idx_ff == i;
  endsequence
  sequence s_wr(logic [7:0] i);
    wr_ph_ff && idx_ff == i;
  endsequence
  a_mode_follow: assert property (s_wr(IDX_MODE) |-> ##2
    portrait == $past(hwdata[7], 2)) else $error("portrait not updated");
  a_alt_follow: assert property (s_wr(IDX_MODE) |-> ##2
    alternate == ($past(hwdata[7], 2) && $past(hwdata[6], 2)))
    else $error("alternate not updated");
  a_land_alt: assert property (!portrait |-> !alternate)
    else $error("alternate set in landscape");
  a_rsvd_zero: assert property (s_rd(IDX_MODE) |->
    hrdata[2] == 1'b0 && hrdata[31:8] == 24'h0)
    else $error("mode read shows reserved bits");
  a_test_zero: assert property (rd_ph_ff && idx_ff[7:1] == 7'h0F
    |-> hrdata == 32'h0) else $error("test register read not zero");
  a_stride_map: assert property (s_wr(IDX_STRIDE) |-> ##2
    stride_bytes == (($past(hwdata[7:0], 2) == 8'h00) ? STRIDE_ZERO :
    {1'b0, $past(hwdata[7:0], 2)})) else $error("stride mapping wrong");
  a_stride_span: assert property (stride_bytes != 9'h000
    && stride_bytes <= STRIDE_ZERO) else $error("stride out of range");
  a_pix_lat: assert property (pix_vld |-> ##2 pix_rgb_vld)
    else $error("pixel output late");
  a_pix_idle: assert property (!pix_vld |-> ##2 !pix_rgb_vld)
    else $error("pixel output without input");
  a_line_gap: assert property (line_start |=> !line_start [*8])
    else $error("line shorter than minimum");
  a_frame_line: assert property (frame_start |-> line_start)
    else $error("frame end not on line end");
  a_pclk_gap: assert property (pclk_en |-> ##[1:16] pclk_en)
    else $error("pixel clock period too long");
  a_mclk_gap: assert property (mclk_en |-> ##[1:16] mclk_en)
    else $error("memory clock period too long");
  a_rdata_idle: assert property (!rd_ph_ff |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule : psc_chk
`default_nettype wire

// *** psc_host.sv ***
// Host processor model issuing single word bus transfers.
`timescale 1ns/1ps
`default_nettype none
module psc_host
  import psc_pkg::*;
(
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hang
);
  // ---------------------------------------------------------------------
  // Transfers.
  // ---------------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hang = 1'b0;
  end
  // A hung slave is flagged rather than waited on forever.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 32);
    if (k >= 32) hang = 1'b1;
  endtask : wait_rdy
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    rd = 32'h0;
    if (wr && idx[7:1] == 7'h0F) return;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= (idx == IDX_MODE) ? (wd & 32'hFFFFFFFB) : wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
endmodule : psc_host
`default_nettype wire

// *** psc_pkg.sv ***
// Constants, register map and types for the portrait clock and stride block.
`default_nettype none

package psc_pkg;

  // ---------------------------------------------------------------------
  // Register word indices; the byte address is four times the index.
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_CLKCFG = 8'h02;
  localparam logic [7:0] IDX_HSIZE = 8'h04;
  localparam logic [7:0] IDX_VSIZE_LO = 8'h05;
  localparam logic [7:0] IDX_VSIZE_HI = 8'h06;
  localparam logic [7:0] IDX_HBLANK = 8'h08;
  localparam logic [7:0] IDX_VBLANK = 8'h0A;
  localparam logic [7:0] IDX_MODE = 8'h1B;
  localparam logic [7:0] IDX_STRIDE = 8'h1C;
  localparam logic [7:0] IDX_TEST_A = 8'h1E;
  localparam logic [7:0] IDX_TEST_B = 8'h1F;
  localparam logic [7:0] IDX_PANEL = 8'h20;
  localparam logic [7:0] IDX_LUT_ADDR = 8'h21;
  localparam logic [7:0] IDX_LUT_DATA = 8'h22;
  localparam logic [7:0] IDX_LINE_LEN = 8'h24;
  localparam logic [7:0] IDX_FRAME_LEN = 8'h25;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // ---------------------------------------------------------------------
  // Field positions and masks.
  // ---------------------------------------------------------------------
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_ALT_BIT = 6;
  localparam int MODE_RSVD_BIT = 2;
  localparam logic [7:0] MODE_MASK = 8'hC3;
  localparam int CLKCFG_INDIV_BIT = 4;
  localparam int CLKCFG_MDIV_BIT = 5;
  localparam logic [7:0] CLKCFG_MASK = 8'h30;
  localparam int PANEL_DUAL_BIT = 0;
  localparam int PANEL_INV_BIT = 1;
  localparam int PANEL_MONO_BIT = 2;
  localparam logic [7:0] PANEL_MASK = 8'h07;
  localparam logic [7:0] HSIZE_MASK = 8'h7F;
  localparam logic [7:0] HBLANK_MASK = 8'h1F;
  localparam logic [7:0] VSIZE_HI_MASK = 8'h03;
  localparam logic [7:0] VBLANK_MASK = 8'h3F;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ---------------------------------------------------------------------
  // Timing arithmetic.
  // ---------------------------------------------------------------------
  localparam int LEN_W = 11;
  localparam int FRAME_W = 24;
  localparam int HUNIT_SHIFT = 3;
  localparam logic [LEN_W-1:0] HBLANK_ADD = 11'h004;
  localparam logic [LEN_W-1:0] ONE_LEN = 11'h001;
  localparam logic [8:0] STRIDE_ZERO = 9'h100;

  // ---------------------------------------------------------------------
  // Look-up stage and clock division.
  // ---------------------------------------------------------------------
  localparam int LUT_DEPTH = 256;
  localparam int LUT_W = 4;
  localparam int RGB_W = 3 * LUT_W;
  localparam logic [1:0] DIV1 = 2'h0;
  localparam logic [1:0] DIV2 = 2'h1;

  typedef enum logic [1:0] {
    PSC_LANDSCAPE = 2'b00,
    PSC_DEFAULT = 2'b01,
    PSC_ALTERNATE = 2'b10
  } psc_mode_t;

endpackage : psc_pkg

`default_nettype wire

// *** psc_top.sv ***
// Portrait mode control, clock division, stride, frame timing and LUT path.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------
// Clock divider producing one-cycle enables.
// -----------------------------------------------------------------------
module psc_div
  import psc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic base_tick,
  input wire logic [1:0] ratio,
  output logic en
);

  logic [2:0] cnt_ff;
  logic [1:0] cur_ff;
  logic [2:0] last;
  logic wrap;
  logic [2:0] nxt_cnt;
  logic [1:0] nxt_cur;
  logic nxt_en;

  // A new ratio is only taken at the end of a whole period, so no output
  // period is ever shorter than the old or the new ratio allows.
  assign last = 3'((4'h1 << cur_ff) - 4'h1);
  assign wrap = base_tick && (cnt_ff == last);
  assign nxt_cnt = !base_tick ? cnt_ff : (wrap ? 3'h0 : 3'(cnt_ff + 3'h1));
  assign nxt_cur = wrap ? ratio : cur_ff;
  assign nxt_en = wrap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 3'h0;
      cur_ff <= DIV1;
      en <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      cur_ff <= nxt_cur;
      en <= nxt_en;
    end
  end

endmodule : psc_div

module psc_top
  import psc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pix_idx,
  input wire logic pix_vld,
  output logic [RGB_W-1:0] pix_rgb,
  output logic pix_rgb_vld,
  output logic pclk_en,
  output logic mclk_en,
  output logic portrait,
  output logic alternate,
  output logic [8:0] stride_bytes,
  output logic line_start,
  output logic frame_start
);

  // ---------------------------------------------------------------------
  // Bus address and data phase.
  // ---------------------------------------------------------------------
  logic dph_wr_ff;
  logic [7:0] dph_idx_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  wire take = hsel && hready && htrans[1];
  wire [7:0] aph_idx = haddr[IDX_MSB:IDX_LSB];
  wire wr_mode = dph_wr_ff && (dph_idx_ff == IDX_MODE);
  wire wr_stride = dph_wr_ff && (dph_idx_ff == IDX_STRIDE);
  wire wr_clkcfg = dph_wr_ff && (dph_idx_ff == IDX_CLKCFG);
  wire wr_hsize = dph_wr_ff && (dph_idx_ff == IDX_HSIZE);
  wire wr_vlo = dph_wr_ff && (dph_idx_ff == IDX_VSIZE_LO);
  wire wr_vhi = dph_wr_ff && (dph_idx_ff == IDX_VSIZE_HI);
  wire wr_hblank = dph_wr_ff && (dph_idx_ff == IDX_HBLANK);
  wire wr_vblank = dph_wr_ff && (dph_idx_ff == IDX_VBLANK);
  wire wr_panel = dph_wr_ff && (dph_idx_ff == IDX_PANEL);
  wire wr_lut_addr = dph_wr_ff && (dph_idx_ff == IDX_LUT_ADDR);
  wire wr_lut_data = dph_wr_ff && (dph_idx_ff == IDX_LUT_DATA);

  // ---------------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------------
  logic [7:0] mode_ff;
  logic [7:0] stride_ff;
  logic [7:0] clkcfg_ff;
  logic [7:0] hsize_ff;
  logic [7:0] vlo_ff;
  logic [7:0] vhi_ff;
  logic [7:0] hblank_ff;
  logic [7:0] vblank_ff;
  logic [7:0] panel_ff;
  logic [7:0] lut_ptr_ff;

  // The reserved mode bit is not stored; software is expected to write
  // zero there and it reads back as zero either way.
  wire [7:0] wbyte = hwdata[7:0];
  wire [7:0] nxt_mode = wr_mode ? (wbyte & MODE_MASK) : mode_ff;
  wire [7:0] nxt_stride = wr_stride ? wbyte : stride_ff;
  wire [7:0] nxt_clkcfg = wr_clkcfg ? (wbyte & CLKCFG_MASK) : clkcfg_ff;
  wire [7:0] nxt_hsize = wr_hsize ? (wbyte & HSIZE_MASK) : hsize_ff;
  wire [7:0] nxt_vlo = wr_vlo ? wbyte : vlo_ff;
  wire [7:0] nxt_vhi = wr_vhi ? (wbyte & VSIZE_HI_MASK) : vhi_ff;
  wire [7:0] nxt_hblank = wr_hblank ? (wbyte & HBLANK_MASK) : hblank_ff;
  wire [7:0] nxt_vblank = wr_vblank ? (wbyte & VBLANK_MASK) : vblank_ff;
  wire [7:0] nxt_panel = wr_panel ? (wbyte & PANEL_MASK) : panel_ff;
  wire [7:0] nxt_lut_ptr = wr_lut_addr ? wbyte :
                           (wr_lut_data ? 8'(lut_ptr_ff + 8'h01) : lut_ptr_ff);

  // The factory test registers hold no storage here: writes are dropped
  // and reads return zero, so a stray write cannot disturb the panel.
  wire test_hit = (aph_idx == IDX_TEST_A) || (aph_idx == IDX_TEST_B);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= RST_BYTE;
      stride_ff <= RST_BYTE;
      clkcfg_ff <= RST_BYTE;
      hsize_ff <= RST_BYTE;
      vlo_ff <= RST_BYTE;
      vhi_ff <= RST_BYTE;
      hblank_ff <= RST_BYTE;
      vblank_ff <= RST_BYTE;
      panel_ff <= RST_BYTE;
      lut_ptr_ff <= RST_BYTE;
    end else begin
      mode_ff <= nxt_mode;
      stride_ff <= nxt_stride;
      clkcfg_ff <= nxt_clkcfg;
      hsize_ff <= nxt_hsize;
      vlo_ff <= nxt_vlo;
      vhi_ff <= nxt_vhi;
      hblank_ff <= nxt_hblank;
      vblank_ff <= nxt_vblank;
      panel_ff <= nxt_panel;
      lut_ptr_ff <= nxt_lut_ptr;
    end
  end

  // ---------------------------------------------------------------------
  // Mode decode.
  // ---------------------------------------------------------------------
  psc_mode_t mode_sel;
  always_comb begin
    if (!mode_ff[MODE_EN_BIT]) begin
      mode_sel = PSC_LANDSCAPE;
    end else if (mode_ff[MODE_ALT_BIT]) begin
      mode_sel = PSC_ALTERNATE;
    end else begin
      mode_sel = PSC_DEFAULT;
    end
  end

  // ---------------------------------------------------------------------
  // Clock derivation.
  // ---------------------------------------------------------------------
  logic half_ff;
  logic [1:0] pratio;
  logic [1:0] mratio;
  wire [1:0] csel = mode_ff[1:0];
  wire base_tick = !clkcfg_ff[CLKCFG_INDIV_BIT] || half_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= !half_ff;
    end
  end

  // Ratios are log2 of the division; the memory clock must stay fast
  // enough for the chosen variant, which software ensures via the select.
  wire land = (mode_sel == PSC_LANDSCAPE);
  wire dflt = (mode_sel == PSC_DEFAULT);
  wire [1:0] land_m = clkcfg_ff[CLKCFG_MDIV_BIT] ? DIV2 : DIV1;
  wire [1:0] alt_p = (csel == DIV1) ? DIV2 : csel;
  wire [1:0] alt_m = (csel == DIV1) ? DIV1 : 2'(csel - 2'h1);
  assign pratio = land ? DIV1 : (dflt ? csel : alt_p);
  assign mratio = land ? land_m : (dflt ? csel : alt_m);

  psc_div u_pdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .base_tick(base_tick),
    .ratio(pratio),
    .en(pclk_en)
  );

  psc_div u_mdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .base_tick(base_tick),
    .ratio(mratio),
    .en(mclk_en)
  );

  // ---------------------------------------------------------------------
  // Frame timing.
  // ---------------------------------------------------------------------
  wire dual = panel_ff[PANEL_DUAL_BIT];
  wire [LEN_W-1:0] horizontal_display_period = LEN_W'({3'h0, hsize_ff} + ONE_LEN) << HUNIT_SHIFT;
  wire [LEN_W-1:0] horizontal_blank_period =
    LEN_W'({3'h0, hblank_ff} + HBLANK_ADD) << HUNIT_SHIFT;
  wire [LEN_W-1:0] vertical_display_period = LEN_W'({1'b0, vhi_ff[1:0], vlo_ff} + ONE_LEN);
  wire [LEN_W-1:0] vertical_blank_period = {3'h0, vblank_ff};
  wire [LEN_W-1:0] hline = LEN_W'(horizontal_display_period + horizontal_blank_period);
  wire [LEN_W:0] line_len = dual ? {hline, 1'b0} : {1'b0, hline};
  wire [LEN_W-1:0] vlines = dual ? LEN_W'((vertical_display_period >> 1) + vertical_blank_period) :
                                   LEN_W'(vertical_display_period + vertical_blank_period);
  wire [FRAME_W-1:0] frame_len = FRAME_W'(line_len * vlines);

  logic [LEN_W:0] line_len_ff;
  logic [FRAME_W-1:0] frame_len_ff;
  logic [LEN_W:0] pix_cnt_ff;
  logic [LEN_W-1:0] line_cnt_ff;
  logic line_start_ff;
  logic frame_start_ff;
  wire line_end = pix_cnt_ff >= (line_len_ff - 12'h001);
  wire frame_end = line_cnt_ff >= (vlines - ONE_LEN);
  wire [LEN_W:0] nxt_pix_cnt = !pclk_en ? pix_cnt_ff :
                               (line_end ? '0 : 12'(pix_cnt_ff + 12'h001));
  wire [LEN_W-1:0] nxt_line_cnt = !(pclk_en && line_end) ? line_cnt_ff :
                                  (frame_end ? '0 : 11'(line_cnt_ff + ONE_LEN));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_len_ff <= '0;
      frame_len_ff <= '0;
      pix_cnt_ff <= '0;
      line_cnt_ff <= '0;
      line_start_ff <= 1'b0;
      frame_start_ff <= 1'b0;
    end else begin
      line_len_ff <= line_len;
      frame_len_ff <= frame_len;
      pix_cnt_ff <= nxt_pix_cnt;
      line_cnt_ff <= nxt_line_cnt;
      line_start_ff <= pclk_en && line_end;
      frame_start_ff <= pclk_en && line_end && frame_end;
    end
  end

  assign line_start = line_start_ff;
  assign frame_start = frame_start_ff;

  // ---------------------------------------------------------------------
  // Colour look-up and inversion.
  // ---------------------------------------------------------------------
  logic [RGB_W-1:0] lut_mem [LUT_DEPTH];
  logic [RGB_W-1:0] lut_rd_ff;
  logic lut_vld_ff;
  logic [RGB_W-1:0] pix_rgb_ff;
  logic pix_rgb_vld_ff;
  wire [LUT_W-1:0] grn = lut_rd_ff[2*LUT_W-1:LUT_W];
  wire [RGB_W-1:0] mapped =
    panel_ff[PANEL_MONO_BIT] ? {grn, grn, grn} : lut_rd_ff;
  wire [RGB_W-1:0] shown =
    panel_ff[PANEL_INV_BIT] ? ~mapped : mapped;

  // The table holds no reset, so it maps to plain memory; software loads
  // it before enabling the display.
  always_ff @(posedge hclk) begin
    if (wr_lut_data) begin
      lut_mem[lut_ptr_ff] <= hwdata[RGB_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lut_rd_ff <= '0;
      lut_vld_ff <= 1'b0;
      pix_rgb_ff <= '0;
      pix_rgb_vld_ff <= 1'b0;
    end else begin
      lut_rd_ff <= lut_mem[pix_idx];
      lut_vld_ff <= pix_vld;
      pix_rgb_ff <= shown;
      pix_rgb_vld_ff <= lut_vld_ff;
    end
  end

  assign pix_rgb = pix_rgb_ff;
  assign pix_rgb_vld = pix_rgb_vld_ff;

  // ---------------------------------------------------------------------
  // Mode and stride outputs.
  // ---------------------------------------------------------------------
  logic portrait_ff;
  logic alternate_ff;
  logic [8:0] stride_bytes_ff;
  wire [8:0] stride_eff = (stride_ff == RST_BYTE) ? STRIDE_ZERO :
                          {1'b0, stride_ff};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portrait_ff <= 1'b0;
      alternate_ff <= 1'b0;
      stride_bytes_ff <= STRIDE_ZERO;
    end else begin
      portrait_ff <= (mode_sel != PSC_LANDSCAPE);
      alternate_ff <= (mode_sel == PSC_ALTERNATE);
      stride_bytes_ff <= stride_eff;
    end
  end

  assign portrait = portrait_ff;
  assign alternate = alternate_ff;
  assign stride_bytes = stride_bytes_ff;

  // ---------------------------------------------------------------------
  // Read mux and bus responses.
  // ---------------------------------------------------------------------
  // Reads look at next-state values so a read right after a write to the
  // same register returns the new value without a wait state, except the LUT data register, where it shows the old content of the next entry.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    unique case (aph_idx)
      IDX_MODE: rd_val = {24'h0, nxt_mode};
      IDX_STRIDE: rd_val = {24'h0, nxt_stride};
      IDX_CLKCFG: rd_val = {24'h0, nxt_clkcfg};
      IDX_HSIZE: rd_val = {24'h0, nxt_hsize};
      IDX_VSIZE_LO: rd_val = {24'h0, nxt_vlo};
      IDX_VSIZE_HI: rd_val = {24'h0, nxt_vhi};
      IDX_HBLANK: rd_val = {24'h0, nxt_hblank};
      IDX_VBLANK: rd_val = {24'h0, nxt_vblank};
      IDX_PANEL: rd_val = {24'h0, nxt_panel};
      IDX_LUT_ADDR: rd_val = {24'h0, nxt_lut_ptr};
      IDX_LUT_DATA: rd_val = {20'h0, lut_mem[nxt_lut_ptr]};
      IDX_LINE_LEN: rd_val = {20'h0, line_len_ff};
      IDX_FRAME_LEN: rd_val = {8'h0, frame_len_ff};
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff <= 1'b0;
      dph_idx_ff <= '0;
      hrdata_ff <= '0;
      hreadyout_ff <= 1'b1;
    end else begin
      dph_wr_ff <= take && hwrite && !test_hit;
      dph_idx_ff <= take ? aph_idx : dph_idx_ff;
      hrdata_ff <= (take && !hwrite) ? rd_val : '0;
      hreadyout_ff <= 1'b1;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;

endmodule : psc_top

`default_nettype wire
